// ===== adcc_control.sv
// Control, start selection, flags and window detector of a 10-bit SAR converter.
// Assumes the analog core holds a stable result on conv_data when told to finish.
`timescale 1ns/10ps
module adcc_control (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register bus
   input wire adcc_pkg::adcc_bus_s bus,
   output logic [7:0] sfr_rdata,
   // Start sources
   input wire adcc_pkg::adcc_timers_s timers,
   input wire logic external_start_pin,
   // Analog core
   input wire logic [9:0] conv_data,
   output logic conv_power_on,
   output logic conv_tracking,
   output logic conv_sample_start,
   output logic conv_in_progress
);
   typedef struct packed {
      logic conv_enable;
      logic track_mode_select;
      logic conv_done_flag;
      logic window_match_flag;
      logic [2:0] start_source_select;
      logic [4:0] sar_div;
      logic left_justify;
      logic [7:0] gt_high;
      logic [7:0] gt_low;
      logic [7:0] lt_high;
      logic [7:0] lt_low;
      logic [7:0] result_high_byte;
      logic [7:0] result_low_byte;
      adcc_pkg::adcc_state_e state;
      logic [3:0] cnt;
      logic ext_prev;
      logic sample_start;
      logic [7:0] rdata;
   } adcc_ctl_s;

   adcc_ctl_s s_reg;
   adcc_ctl_s s_next;
   logic sar_tick;
   logic [7:0] ctrl_now;
   logic [7:0] ctrl_wd;
   logic ctrl_write;
   logic busy_write_one;
   logic trigger;
   logic start;
   logic done_evt;
   logic [7:0] new_high;
   logic [7:0] new_low;
   logic [15:0] word;
   logic [15:0] gt_word;
   logic [15:0] lt_word;
   logic match;
   logic [3:0] t_ovf;

   // The divider only runs inside a conversion so every delay starts on a fresh phase.
   adcc_sar_divider u_div (
      .clock(clock),
      .rst(rst),
      .run(s_reg.state != adcc_pkg::ST_IDLE),
      .div(s_reg.sar_div),
      .tick(sar_tick)
   );

   always_comb begin
      ctrl_now = {s_reg.conv_enable, s_reg.track_mode_select, s_reg.conv_done_flag,
                  s_reg.state != adcc_pkg::ST_IDLE, s_reg.window_match_flag,
                  s_reg.start_source_select};
      ctrl_write = (bus.wr || bus.bit_wr) && bus.addr == adcc_pkg::ADDR_CONVERTER_CONTROL;
      ctrl_wd = ctrl_now;
      if (bus.wr) begin
         ctrl_wd = bus.wdata;
      end else if (bus.bit_wr) begin
         ctrl_wd[bus.bit_idx] = bus.bit_val;
      end
      busy_write_one = ctrl_write && ctrl_wd[adcc_pkg::CTRL_BUSY_BIT] &&
                       (bus.wr || bus.bit_idx == adcc_pkg::CTRL_BUSY_BIT);
      t_ovf = (timers.split8 & timers.ovf_low) | (~timers.split8 & timers.ovf_high);
      trigger = 1'b0;
      unique case (s_reg.start_source_select)
         adcc_pkg::START_SOFTWARE: trigger = busy_write_one;
         adcc_pkg::START_TIMER0: trigger = timers.ovf0;
         adcc_pkg::START_TIMER2: trigger = t_ovf[0];
         adcc_pkg::START_TIMER1: trigger = timers.ovf1;
         adcc_pkg::START_EXT_PIN: trigger = external_start_pin && !s_reg.ext_prev;
         adcc_pkg::START_TIMER3: trigger = t_ovf[1];
         adcc_pkg::START_TIMER4: trigger = t_ovf[2];
         adcc_pkg::START_TIMER5: trigger = t_ovf[3];
      endcase
      start = s_reg.conv_enable && s_reg.state == adcc_pkg::ST_IDLE && trigger;
      done_evt = s_reg.conv_enable && s_reg.state == adcc_pkg::ST_CONVERT && sar_tick &&
                 s_reg.cnt == adcc_pkg::CONV_SAR_CLKS - adcc_pkg::COUNT_ONE;
      if (s_reg.left_justify) begin
         new_high = conv_data[9:2];
         new_low = {conv_data[1:0], 6'h00};
      end else begin
         new_high = {6'h00, conv_data[9:8]};
         new_low = conv_data[7:0];
      end
      word = {new_high, new_low};
      gt_word = {s_reg.gt_high, s_reg.gt_low};
      lt_word = {s_reg.lt_high, s_reg.lt_low};
      if (lt_word > gt_word) begin
         match = word > gt_word && word < lt_word;
      end else begin
         match = word > gt_word || word < lt_word;
      end

      s_next = s_reg;
      s_next.ext_prev = external_start_pin;
      s_next.sample_start = 1'b0;
      if (ctrl_write) begin
         s_next.conv_enable = ctrl_wd[adcc_pkg::CTRL_ENABLE_BIT];
         s_next.track_mode_select = ctrl_wd[adcc_pkg::CTRL_TRACK_BIT];
         s_next.conv_done_flag = ctrl_wd[adcc_pkg::CTRL_DONE_BIT];
         s_next.window_match_flag = ctrl_wd[adcc_pkg::CTRL_WINDOW_BIT];
         s_next.start_source_select = ctrl_wd[2:0];
      end
      if (bus.wr) begin
         unique case (bus.addr)
            adcc_pkg::ADDR_CONVERTER_CONFIG: begin
               s_next.sar_div = bus.wdata[7:3];
               s_next.left_justify = bus.wdata[2];
            end
            adcc_pkg::ADDR_WINDOW_GREATER_LIMIT_HIGH: s_next.gt_high = bus.wdata;
            adcc_pkg::ADDR_WINDOW_GREATER_LIMIT_LOW: s_next.gt_low = bus.wdata;
            adcc_pkg::ADDR_WINDOW_LESS_LIMIT_HIGH: s_next.lt_high = bus.wdata;
            adcc_pkg::ADDR_WINDOW_LESS_LIMIT_LOW: s_next.lt_low = bus.wdata;
            adcc_pkg::ADDR_RESULT_HIGH_BYTE: s_next.result_high_byte = bus.wdata;
            adcc_pkg::ADDR_RESULT_LOW_BYTE: s_next.result_low_byte = bus.wdata;
            default: ;
         endcase
      end

      unique case (s_reg.state)
         adcc_pkg::ST_IDLE: begin
            s_next.cnt = 4'h0;
            if (start) begin
               if (s_reg.track_mode_select &&
                   s_reg.start_source_select != adcc_pkg::START_EXT_PIN) begin
                  s_next.state = adcc_pkg::ST_TRACK;
               end else begin
                  s_next.state = adcc_pkg::ST_CONVERT;
                  s_next.sample_start = 1'b1;
               end
            end
         end
         adcc_pkg::ST_TRACK: begin
            if (sar_tick) begin
               s_next.cnt = s_reg.cnt + adcc_pkg::COUNT_ONE;
               if (s_reg.cnt == adcc_pkg::TRACK_SAR_CLKS - adcc_pkg::COUNT_ONE) begin
                  s_next.state = adcc_pkg::ST_CONVERT;
                  s_next.cnt = 4'h0;
                  s_next.sample_start = 1'b1;
               end
            end
         end
         adcc_pkg::ST_CONVERT: begin
            if (sar_tick) begin
               s_next.cnt = s_reg.cnt + adcc_pkg::COUNT_ONE;
            end
            if (done_evt) begin
               s_next.state = adcc_pkg::ST_IDLE;
               s_next.result_high_byte = new_high;
               s_next.result_low_byte = new_low;
               s_next.conv_done_flag = 1'b1;
               if (match) begin
                  s_next.window_match_flag = 1'b1;
               end
            end
         end
      endcase
      if (!s_reg.conv_enable) begin
         s_next.state = adcc_pkg::ST_IDLE;
         s_next.cnt = 4'h0;
         // A track phase cut by shutdown must not leave a stray sample pulse behind.
         s_next.sample_start = 1'b0;
      end

      if (bus.rd) begin
         unique case (bus.addr)
            adcc_pkg::ADDR_CONVERTER_CONTROL: s_next.rdata = ctrl_now;
            adcc_pkg::ADDR_CONVERTER_CONFIG: s_next.rdata = {s_reg.sar_div,
                                                              s_reg.left_justify, 2'h0};
            adcc_pkg::ADDR_WINDOW_GREATER_LIMIT_HIGH: s_next.rdata = s_reg.gt_high;
            adcc_pkg::ADDR_WINDOW_GREATER_LIMIT_LOW: s_next.rdata = s_reg.gt_low;
            adcc_pkg::ADDR_WINDOW_LESS_LIMIT_HIGH: s_next.rdata = s_reg.lt_high;
            adcc_pkg::ADDR_WINDOW_LESS_LIMIT_LOW: s_next.rdata = s_reg.lt_low;
            adcc_pkg::ADDR_RESULT_HIGH_BYTE: s_next.rdata = s_reg.result_high_byte;
            adcc_pkg::ADDR_RESULT_LOW_BYTE: s_next.rdata = s_reg.result_low_byte;
            default: s_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.sar_div <= adcc_pkg::SAR_DIVIDER_RESET;
         s_reg.gt_high <= adcc_pkg::GREATER_LIMIT_RESET;
         s_reg.gt_low <= adcc_pkg::GREATER_LIMIT_RESET;
         s_reg.lt_high <= adcc_pkg::LESS_LIMIT_RESET;
         s_reg.lt_low <= adcc_pkg::LESS_LIMIT_RESET;
         s_reg.result_high_byte <= adcc_pkg::RESULT_RESET;
         s_reg.result_low_byte <= adcc_pkg::RESULT_RESET;
         s_reg.state <= adcc_pkg::ST_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sfr_rdata = s_reg.rdata;
   assign conv_power_on = s_reg.conv_enable;
   assign conv_tracking = s_reg.conv_enable && s_reg.state != adcc_pkg::ST_CONVERT;
   assign conv_sample_start = s_reg.sample_start;
   assign conv_in_progress = s_reg.state == adcc_pkg::ST_CONVERT;
endmodule

// ===== adcc_pkg.sv
// Shared constants and carriers for the converter control block.
// Assumes an 8-bit special function register bus with byte and bit writes.
package adcc_pkg;
   // Register addresses on the special function register bus.
   localparam logic [7:0] ADDR_CONVERTER_CONTROL = 8'he8;
   localparam logic [7:0] ADDR_WINDOW_GREATER_LIMIT_HIGH = 8'hc4;
   localparam logic [7:0] ADDR_WINDOW_GREATER_LIMIT_LOW = 8'hc3;
   localparam logic [7:0] ADDR_WINDOW_LESS_LIMIT_HIGH = 8'hc6;
   localparam logic [7:0] ADDR_WINDOW_LESS_LIMIT_LOW = 8'hc5;
   localparam logic [7:0] ADDR_CONVERTER_CONFIG = 8'hbc;
   localparam logic [7:0] ADDR_RESULT_HIGH_BYTE = 8'hbe;
   localparam logic [7:0] ADDR_RESULT_LOW_BYTE = 8'hbd;

   // Bit positions in the control register.
   localparam logic [2:0] CTRL_ENABLE_BIT = 3'h7;
   localparam logic [2:0] CTRL_TRACK_BIT = 3'h6;
   localparam logic [2:0] CTRL_DONE_BIT = 3'h5;
   localparam logic [2:0] CTRL_BUSY_BIT = 3'h4;
   localparam logic [2:0] CTRL_WINDOW_BIT = 3'h3;

   // Reset values.
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] GREATER_LIMIT_RESET = 8'hff;
   localparam logic [7:0] LESS_LIMIT_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [4:0] SAR_DIVIDER_RESET = 5'h1f;

   // Start source codes.
   localparam logic [2:0] START_SOFTWARE = 3'h0;
   localparam logic [2:0] START_TIMER0 = 3'h1;
   localparam logic [2:0] START_TIMER2 = 3'h2;
   localparam logic [2:0] START_TIMER1 = 3'h3;
   localparam logic [2:0] START_EXT_PIN = 3'h4;
   localparam logic [2:0] START_TIMER3 = 3'h5;
   localparam logic [2:0] START_TIMER4 = 3'h6;
   localparam logic [2:0] START_TIMER5 = 3'h7;

   // Durations in SAR clock periods.
   localparam logic [3:0] TRACK_SAR_CLKS = 4'h3;
   localparam logic [3:0] CONV_SAR_CLKS = 4'hb;
   localparam logic [3:0] COUNT_ONE = 4'h1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRACK,
      ST_CONVERT
   } adcc_state_e;

   // Register bus request.
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic [7:0] wdata;
      logic bit_wr;
      logic [2:0] bit_idx;
      logic bit_val;
      logic rd;
   } adcc_bus_s;

   // Timer overflow events and split8 mode selects feeding the start selector.
   typedef struct packed {
      logic ovf0;
      logic ovf1;
      logic [3:0] ovf_low;
      logic [3:0] ovf_high;
      logic [3:0] split8;
   } adcc_timers_s;
endpackage

// ===== adcc_sar_divider.sv
// SAR clock enable generator: one tick every div+1 system clocks.
// Assumes run is low between conversions so each phase starts aligned.
`timescale 1ns/10ps
module adcc_sar_divider (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Control
   input wire logic run,
   input wire logic [4:0] div,
   // Tick
   output logic tick
);
   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } adcc_div_s;

   adcc_div_s s_reg;
   adcc_div_s s_next;

   always_comb begin
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (!run) begin
         s_next.cnt = 5'h00;
      end else if (s_reg.cnt == div) begin
         s_next.cnt = 5'h00;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + 5'h01;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;
endmodule

// ===== adcc_core_model.sv
// Behavioural analog core that answers the control block with a result word.
// Assumes conv_sample_start marks the first cycle of each conversion.
`timescale 1ns/10ps
module adcc_core_model (
   // Clock
   input wire logic clock,
   // Converter handshake
   input wire logic conv_sample_start,
   input wire logic conv_in_progress,
   input wire logic [9:0] level,
   // Result
   output logic [9:0] conv_data
);
   logic [9:0] held_reg;
   always_ff @(posedge clock) begin
      if (conv_sample_start) begin
         held_reg <= level;
      end
   end
   // The word is only valid while converting, so the inverse shows early or late sampling.
   assign conv_data = conv_in_progress ? held_reg : ~held_reg;
endmodule

// ===== adcc_control_monitor.sv
// Port assertions for the converter control block.
// Assumes it is bound onto adcc_control and sees only its ports.
`timescale 1ns/10ps
module adcc_control_monitor (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus and start sources
   input wire adcc_pkg::adcc_bus_s bus,
   input wire logic [7:0] sfr_rdata,
   input wire adcc_pkg::adcc_timers_s timers,
   input wire logic external_start_pin,
   // Analog core
   input wire logic [9:0] conv_data,
   input wire logic conv_power_on,
   input wire logic conv_tracking,
   input wire logic conv_sample_start,
   input wire logic conv_in_progress
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic ctrl_rd;
   assign ctrl_rd = bus.rd && !bus.wr && bus.addr == adcc_pkg::ADDR_CONVERTER_CONTROL;
   shutdown_idle_a: assert property (!conv_power_on |=> !conv_in_progress)
      else $error("converting while shut down");
   start_power_a: assert property (conv_sample_start |-> conv_power_on)
      else $error("start while disabled");
   track_level_a: assert property (conv_tracking == (conv_power_on && !conv_in_progress))
      else $error("tracking level wrong");
   start_pulse_a: assert property (conv_sample_start == $rose(conv_in_progress))
      else $error("sample start not at convert entry");
   busy_end_a: assert property (conv_sample_start |-> ##[1:400] !conv_in_progress)
      else $error("conversion never ends");
   busy_read_a: assert property (ctrl_rd && conv_in_progress |=> sfr_rdata[4])
      else $error("busy bit low while converting");
   unmapped_read_a: assert property (
      bus.rd && !bus.wr && bus.addr == 8'h00 |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   reset_read_a: assert property (disable iff (1'b0) rst |=> sfr_rdata == 8'h00)
      else $error("read data not cleared by reset");
   cover property (conv_sample_start);
   cover property ($fell(conv_in_progress));
   cover property (ctrl_rd && conv_in_progress);
endmodule
bind adcc_control adcc_control_monitor i_mon (.clock(clock), .rst(rst), .bus(bus),
   .sfr_rdata(sfr_rdata), .timers(timers), .external_start_pin(external_start_pin),
   .conv_data(conv_data), .conv_power_on(conv_power_on), .conv_tracking(conv_tracking),
   .conv_sample_start(conv_sample_start), .conv_in_progress(conv_in_progress));

// ===== adcc_control_tb_top.sv
// Self-checking bench for the converter control block.
// Assumes the core model supplies conv_data and the monitor is bound in.
`timescale 1ns/10ps
module adcc_control_tb_top;
   typedef struct packed {
      logic [2:0] mode;
      logic [3:0] good;
      logic [3:0] bad;
      logic [3:0] split;
      logic [15:0] gt;
      logic [15:0] lt;
      logic [9:0] d;
      logic win;
   } adcc_row_s;
   localparam logic [7:0] CC = adcc_pkg::ADDR_CONVERTER_CONTROL;
   logic clock = 1'b0;
   logic rst = 1'b1;
   adcc_pkg::adcc_bus_s bus = '0;
   adcc_pkg::adcc_timers_s tmr = '0;
   logic pin = 1'b0;
   logic [9:0] level = 10'h000;
   logic [9:0] conv_data;
   logic [7:0] sfr_rdata, v;
   logic power_on, tracking, sample_start, in_progress;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;
   adcc_row_s rows [8];
   always #2.5 clock = ~clock;
   adcc_control i_dut (.clock(clock), .rst(rst), .bus(bus), .sfr_rdata(sfr_rdata),
      .timers(tmr), .external_start_pin(pin), .conv_data(conv_data),
      .conv_power_on(power_on), .conv_tracking(tracking),
      .conv_sample_start(sample_start), .conv_in_progress(in_progress));
   adcc_core_model i_core (.clock(clock), .conv_sample_start(sample_start),
      .conv_in_progress(in_progress), .level(level), .conv_data(conv_data));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bit_op);
      @(negedge clock);
      bus.addr = a;
      bus.wdata = d;
      bus.bit_idx = d[2:0];
      bus.bit_val = d[7];
      bus.wr = !bit_op;
      bus.bit_wr = bit_op;
      @(negedge clock);
      bus.wr = 1'b0;
      bus.bit_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      bus.addr = a;
      bus.rd = 1'b1;
      @(negedge clock);
      bus.rd = 1'b0;
      d = sfr_rdata;
   endtask
   task automatic pulses(input logic [3:0] s);
      tmr.ovf0 = (s == 4'h1);
      tmr.ovf1 = (s == 4'h2);
      tmr.ovf_high = (s inside {[4'h3:4'h6]}) ? 4'h1 << (s - 4'h3) : 4'h0;
      tmr.ovf_low = (s inside {[4'h8:4'hb]}) ? 4'h1 << (s - 4'h8) : 4'h0;
      pin = (s == 4'h7);
   endtask
   task automatic fire(input logic [3:0] s, input logic [7:0] ctrl);
      if (s == 4'h0) begin
         wr(CC, ctrl | 8'h10, 1'b0);
      end else begin
         @(negedge clock);
         pulses(s);
         @(negedge clock);
         pulses(4'hf);
      end
   endtask
   task automatic wait_start(output int cnt);
      cnt = 0;
      while (sample_start !== 1'b1 && cnt < 20) begin
         @(negedge clock);
         cnt++;
      end
   endtask
   task automatic wait_done();
      for (int k = 0; k < 400 && in_progress !== 1'b0; k++) @(negedge clock);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      rows[0] = '{3'h0, 4'h0, 4'h1, 4'h0, 16'h0040, 16'h0080, 10'h041, 1'b1};
      rows[1] = '{3'h1, 4'h1, 4'h2, 4'h0, 16'h0040, 16'h0080, 10'h040, 1'b0};
      rows[2] = '{3'h2, 4'h8, 4'h3, 4'h1, 16'h0080, 16'h0040, 10'h03f, 1'b1};
      rows[3] = '{3'h3, 4'h2, 4'h1, 4'h0, 16'h0080, 16'h0040, 10'h060, 1'b0};
      rows[4] = '{3'h4, 4'h7, 4'h0, 4'h0, 16'h0080, 16'h0040, 10'h3ff, 1'b1};
      rows[5] = '{3'h5, 4'h4, 4'h9, 4'h0, 16'h0080, 16'h0040, 10'h080, 1'b0};
      rows[6] = '{3'h6, 4'ha, 4'h5, 4'h4, 16'hffff, 16'h0000, 10'h155, 1'b0};
      rows[7] = '{3'h7, 4'h6, 4'hb, 4'h0, 16'h0000, 16'h0000, 10'h001, 1'b1};
      repeat (10) @(negedge clock);
      rst = 1'b0;
      wr(8'hbc, 8'h00, 1'b0);
      foreach (rows[i]) begin
         tmr.split8 = rows[i].split;
         level = rows[i].d;
         wr(8'hc4, rows[i].gt[15:8], 1'b0);
         wr(8'hc3, rows[i].gt[7:0], 1'b0);
         wr(8'hc6, rows[i].lt[15:8], 1'b0);
         wr(8'hc5, rows[i].lt[7:0], 1'b0);
         wr(CC, {5'h10, rows[i].mode}, 1'b0);
         fire(rows[i].bad, {5'h10, rows[i].mode});
         wait_start(n);
         check(16'(n), 16'd20, "start from other source");
         fire(rows[i].good, {5'h10, rows[i].mode});
         wait_start(n);
         check(16'(n), 16'd0, "start delay");
         check({15'h0000, tracking}, 16'h0000, "tracking while converting");
         wait_done();
         rd(CC, v);
         check({8'h00, v}, {8'h00, 4'ha, rows[i].win, rows[i].mode},
            "control after done");
         rd(8'hbe, v);
         check({8'h00, v}, {14'h0000, rows[i].d[9:8]}, "result high");
         rd(8'hbd, v);
         check({8'h00, v}, {8'h00, rows[i].d[7:0]}, "result low");
         check({15'h0000, tracking}, 16'h0001, "tracking when idle");
         wr(CC, 8'h00, 1'b0);
      end
      level = 10'h2c5;
      wr(8'hbc, 8'h1c, 1'b0);
      wr(CC, 8'hc0, 1'b0);
      fire(4'h0, 8'hc0);
      wait_start(n);
      check({15'h0000, n > 8 && n < 20}, 16'h0001, "delayed start");
      rd(CC, v);
      check({15'h0000, v[4]}, 16'h0001, "busy while converting");
      wait_done();
      rd(8'hbe, v);
      check({8'h00, v}, 16'h00b1, "left justified high");
      rd(8'hbd, v);
      check({8'h00, v}, 16'h0040, "left justified low");
      wr(CC, 8'hc4, 1'b0);
      fire(4'h7, 8'hc4);
      wait_start(n);
      check(16'(n), 16'd0, "pin start delay");
      wait_done();
      rd(CC, v);
      check({8'h00, v}, 16'h00ec, "flags after pin start");
      wr(CC, 8'h05, 1'b1);
      rd(CC, v);
      check({8'h00, v}, 16'h00cc, "done bit clear");
      wr(CC, 8'h10, 1'b0);
      wr(CC, 8'h10, 1'b0);
      wait_start(n);
      check({power_on, 15'(n)}, 16'd20, "start while shut down");
      rst = 1'b1;
      repeat (10) @(negedge clock);
      rst = 1'b0;
      rd(CC, v);
      check({8'h00, v}, 16'h0000, "control reset");
      check({14'h0000, power_on, tracking}, 16'h0000, "outputs after reset");
      rd(8'hc4, v);
      check({8'h00, v}, 16'h00ff, "greater high reset");
      rd(8'h00, v);
      check({8'h00, v}, 16'h0000, "unmapped read");
      wr(8'hc4, 8'h5a, 1'b0);
      rd(8'hc4, v);
      check({8'h00, v}, 16'h005a, "greater high write");
      end_of_test();
   end
endmodule
